// File: common/hpmm_defs.svh
// Address map, field positions, reset values and timing constants of the Hall pattern modulation block
`ifndef HPMM_DEFS_SVH
`define HPMM_DEFS_SVH

// Register byte addresses
`define HPMM_ADDR_MODCTL 16'hE8C0
`define HPMM_ADDR_SHADOW 16'hE8C4
`define HPMM_ADDR_ACTIVE 16'hE8C8
`define HPMM_ADDR_XFRCTL 16'hE8CC
`define HPMM_ADDR_STATUS 16'hE8D0

// Output modulation control fields
`define HPMM_MOD_TMRB_OE 15
`define HPMM_MOD_TMRB_EN_HI 13
`define HPMM_MOD_TMRB_EN_LO 8
`define HPMM_MOD_MCM_EN 7
`define HPMM_MOD_TMRA_EN_HI 5
`define HPMM_MOD_TMRA_EN_LO 0
`define HPMM_MOD_RST 16'h0000
`define HPMM_MOD_MASK 16'hBFBF

// Shadow and active pattern fields
`define HPMM_PAT_HALL_REQ 15
`define HPMM_PAT_OUT_REQ 14
`define HPMM_PAT_CUR_HI 13
`define HPMM_PAT_CUR_LO 11
`define HPMM_PAT_EXP_HI 10
`define HPMM_PAT_EXP_LO 8
`define HPMM_PAT_OUT_HI 5
`define HPMM_PAT_OUT_LO 0

// Transfer control fields
`define HPMM_XFR_TRIG_HI 2
`define HPMM_XFR_TRIG_LO 0
`define HPMM_XFR_SYNC_HI 5
`define HPMM_XFR_SYNC_LO 4
`define HPMM_XFR_FILT_EN 6
`define HPMM_XFR_RELOAD_HI 15
`define HPMM_XFR_RELOAD_LO 8
`define HPMM_XFR_RST 16'h0000

// Status fields
`define HPMM_STS_DONE 0
`define HPMM_STS_REMIND 1
`define HPMM_STS_HALL_HI 4
`define HPMM_STS_HALL_LO 2

// Dead-time counter fires when it reaches this value
`define HPMM_DTC_FIRE 8'h01

`endif

// File: common/hpmm_pkg.sv
// Types shared by the Hall pattern modulation block
`default_nettype none
package hpmm_pkg;
  typedef logic [2:0] hpmm_hall_t;
  typedef logic [5:0] hpmm_outs_t;

  // Trigger event select codes
  typedef enum logic [2:0] {
    HPMM_TRIG_NONE = 3'h0,
    HPMM_TRIG_CHE = 3'h1,
    HPMM_TRIG_TMRB_PM = 3'h2,
    HPMM_TRIG_TMRA_OM_DN = 3'h3,
    HPMM_TRIG_TMRA_CH1_UP = 3'h4,
    HPMM_TRIG_TMRA_PM_UP = 3'h5,
    HPMM_TRIG_RSV6 = 3'h6,
    HPMM_TRIG_RSV7 = 3'h7
  } hpmm_trig_t;

  // Synchronisation event select codes
  typedef enum logic [1:0] {
    HPMM_SYNC_DIRECT = 2'h0,
    HPMM_SYNC_TMRB_ZM = 2'h1,
    HPMM_SYNC_TMRA_ZM_UP = 2'h2,
    HPMM_SYNC_RSV = 2'h3
  } hpmm_sync_t;
endpackage
`default_nettype wire

// File: src/hpmm_hall_filter.sv
// Hall input synchroniser, edge detector and dead-time delay filter
`include "hpmm_defs.svh"
`default_nettype none
module hpmm_hall_filter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Hall inputs and configuration
  input wire logic [2:0] hall_in,
  input wire logic filter_en,
  input wire logic [7:0] reload,
  // Sampled pattern and compare-ready strobe
  output logic [2:0] sample,
  output logic compare_ready
);
  logic [2:0] sync1_ff, sync2_ff, prev_ff;
  logic [7:0] dtc_ff;
  logic edge_det;
  logic fire;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      prev_ff <= 3'h0;
    end else begin
      sync1_ff <= hall_in; // R22
      sync2_ff <= sync1_ff; // R22
      prev_ff <= sync2_ff;
    end
  end

  // Any level change on any input
  assign edge_det = |(sync2_ff ^ prev_ff); // R15
  assign fire = filter_en ? (dtc_ff == `HPMM_DTC_FIRE) : edge_det;

  // Dead-time counter 0: each edge reloads, so bouncing pushes sampling out
  always_ff @(posedge clk) begin
    if (rst) begin
      dtc_ff <= 8'h00;
    end else if (edge_det && filter_en) begin
      dtc_ff <= (reload == 8'h00) ? `HPMM_DTC_FIRE : reload; // R17
    end else if (dtc_ff != 8'h00) begin
      dtc_ff <= dtc_ff - 8'h01;
    end
  end

  // Sample inputs and strobe compare-ready when counter reaches one, or on each edge with the filter off
  always_ff @(posedge clk) begin
    if (rst) begin
      sample <= 3'h0;
      compare_ready <= 1'b0;
    end else begin
      compare_ready <= fire; // R18
      if (fire) begin
        sample <= sync2_ff; // R18
      end
    end
  end
endmodule // hpmm_hall_filter
`default_nettype wire

// File: src/hpmm_top.sv
// Hall pattern compare, pattern shadow transfers and multi-channel output modulation
//
// Summary of operation
// (R01) Sync code 00 transfers directly on trigger
// (R02) Sync 01 timer_b zero, 10 timer_a zero-up
// (R03) Bit 15 low forces timer_b compare output
// (R04) Timer_b enables bits 13..8, timer_a 5..0
// (R05) Enable bits map ch2n,ch2,ch1n,ch1,ch0n,ch0
// (R06) Bit 7 enables multi-channel pattern modulation
// (R07) Active and shadow pattern registers kept
// (R08) Sample equals expected gives correct event
// (R09) Sample equals current is noise, no event
// (R10) Neither match gives wrong Hall event
// (R11) Correct event copies Hall shadows to active
// (R12) Output pattern moves only on transfer strobe
// (R13) Hall request bit forces immediate Hall copy
// (R14) Phase delay applies pattern on strobe, flags done
// (R15) Edge pulse on any Hall input change
// (R16) Software sets all channel modes to 1000
// (R17) Edge reloads and starts dead-time counter
// (R18) Counter at one strobes sampling and compare
// (R19) Multi-channel passes only pattern-enabled outputs
// (R20) Reminder set on event, cleared on transfer
// (R21) Trigger select codes 000 to 101 decoded
// (R22) Two-stage synchroniser on Hall inputs
//
// Our own choice: the APB slave port.
`include "hpmm_defs.svh"
`default_nettype none
module hpmm_top (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Hall sensor inputs
  input wire logic [2:0] HALL_INPUT,
  // Timer events, one-cycle pulses
  input wire logic TMRB_ZERO_MATCH,
  input wire logic TMRB_PERIOD_MATCH,
  input wire logic TMRA_ZERO_MATCH_UP,
  input wire logic TMRA_ONE_MATCH_DOWN,
  input wire logic TMRA_CH1_COMPARE_UP,
  input wire logic TMRA_PERIOD_MATCH_UP,
  // Timer PWM patterns per output, bit order ch2n,ch2,ch1n,ch1,ch0n,ch0
  input wire logic [5:0] TMRA_PWM,
  input wire logic [5:0] TMRB_PWM,
  input wire logic TMRB_COMPARE_RAW,
  // Modulated outputs toward the inverter
  output logic [5:0] OUTPUT_MOD,
  output logic TIMER_B_COMPARE_OUTPUT,
  // Event strobes
  output logic CORRECT_HALL_EVENT,
  output logic WRONG_HALL_EVENT,
  output logic PATTERN_TRANSFER_STROBE
);
  // Software-visible control registers
  logic [15:0] output_modulation_control_ff;
  logic [15:0] xfer_ctl_ff;
  // Active and shadow pattern registers
  hpmm_pkg::hpmm_hall_t current_hall_pattern_ff, expected_hall_pattern_ff;
  hpmm_pkg::hpmm_hall_t current_hall_shadow_ff, expected_hall_shadow_ff;
  hpmm_pkg::hpmm_outs_t output_pattern_ff, output_pattern_shadow_ff;
  // Transfer bookkeeping flags
  logic reminder_ff, nxt_reminder;
  logic transfer_done_flag_ff;
  // Filter results
  logic [2:0] hall_sample;
  logic compare_ready;
  // Bus decode and event selection
  logic wr_en, rd_setup, addr_ok;
  logic wr_mod, wr_shadow, wr_xfer, wr_status;
  logic hall_sw_req, out_sw_req;
  logic match_exp, match_cur;
  logic trig_event, sync_event, strobe;
  logic [31:0] nxt_prdata;
  hpmm_pkg::hpmm_trig_t trig_sel;
  hpmm_pkg::hpmm_sync_t sync_sel;

  // Output of one channel: timer sources, optionally gated by the pattern
  function automatic logic mod_out(input logic a_en, input logic a_pwm, input logic b_en,
                                   input logic b_pwm, input logic mcm_en, input logic pat);
    logic tmr;
    tmr = (a_en & a_pwm) | (b_en & b_pwm);
    // An output with no timer source enabled follows the pattern when multi-channel modulation is on, else stays low
    if (!(a_en | b_en)) begin
      tmr = mcm_en;
    end
    mod_out = tmr & (pat | ~mcm_en);
  endfunction

  // Address match against the implemented registers
  function automatic logic addr_hit(input logic [15:0] a);
    addr_hit = (a == `HPMM_ADDR_MODCTL) || (a == `HPMM_ADDR_SHADOW) || (a == `HPMM_ADDR_ACTIVE) ||
               (a == `HPMM_ADDR_XFRCTL) || (a == `HPMM_ADDR_STATUS);
  endfunction

  // Hall input conditioning and delayed sampling
  hpmm_hall_filter u_filter (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .hall_in(HALL_INPUT),
    .filter_en(xfer_ctl_ff[`HPMM_XFR_FILT_EN]),
    .reload(xfer_ctl_ff[`HPMM_XFR_RELOAD_HI:`HPMM_XFR_RELOAD_LO]),
    .sample(hall_sample),
    .compare_ready(compare_ready)
  );

  // APB decode; zero wait states, so every access completes in its first access cycle
  assign PREADY = 1'b1;
  assign addr_ok = addr_hit(PADDR);
  assign PSLVERR = PSEL & PENABLE & ~addr_ok;
  assign wr_en = PSEL & PENABLE & PWRITE & addr_ok;
  assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
  assign wr_mod = wr_en && (PADDR == `HPMM_ADDR_MODCTL);
  assign wr_shadow = wr_en && (PADDR == `HPMM_ADDR_SHADOW);
  assign wr_xfer = wr_en && (PADDR == `HPMM_ADDR_XFRCTL);
  assign wr_status = wr_en && (PADDR == `HPMM_ADDR_STATUS);
  assign hall_sw_req = wr_shadow & PWDATA[`HPMM_PAT_HALL_REQ];
  assign out_sw_req = wr_shadow & PWDATA[`HPMM_PAT_OUT_REQ];

  // Select fields taken from transfer control; reserved codes decode to no action
  assign trig_sel = hpmm_pkg::hpmm_trig_t'(xfer_ctl_ff[`HPMM_XFR_TRIG_HI:`HPMM_XFR_TRIG_LO]);
  assign sync_sel = hpmm_pkg::hpmm_sync_t'(xfer_ctl_ff[`HPMM_XFR_SYNC_HI:`HPMM_XFR_SYNC_LO]);

  // Comparators, evaluated only on compare-ready; expected wins if both match
  // With the filter on, a spike that settles back to the current pattern is dropped without a trace
  assign match_exp = compare_ready && (hall_sample == expected_hall_pattern_ff); // R08
  assign match_cur = compare_ready && (hall_sample == current_hall_pattern_ff); // R09

  // Hall event strobes, registered one cycle after compare-ready
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      CORRECT_HALL_EVENT <= 1'b0;
      WRONG_HALL_EVENT <= 1'b0;
    end else begin
      CORRECT_HALL_EVENT <= match_exp; // R08
      WRONG_HALL_EVENT <= compare_ready & ~match_exp & ~match_cur; // R09 R10
    end
  end

  // Trigger event selection; reserved codes select nothing
  always_comb begin
    unique case (trig_sel)
      hpmm_pkg::HPMM_TRIG_NONE: trig_event = 1'b0; // R21
      hpmm_pkg::HPMM_TRIG_CHE: trig_event = CORRECT_HALL_EVENT; // R21
      hpmm_pkg::HPMM_TRIG_TMRB_PM: trig_event = TMRB_PERIOD_MATCH; // R21
      hpmm_pkg::HPMM_TRIG_TMRA_OM_DN: trig_event = TMRA_ONE_MATCH_DOWN; // R21
      hpmm_pkg::HPMM_TRIG_TMRA_CH1_UP: trig_event = TMRA_CH1_COMPARE_UP; // R21 R14
      hpmm_pkg::HPMM_TRIG_TMRA_PM_UP: trig_event = TMRA_PERIOD_MATCH_UP; // R21
      hpmm_pkg::HPMM_TRIG_RSV6: trig_event = 1'b0;
      hpmm_pkg::HPMM_TRIG_RSV7: trig_event = 1'b0;
    endcase
  end

  // Synchronisation event; in direct mode the trigger itself transfers
  always_comb begin
    unique case (sync_sel)
      hpmm_pkg::HPMM_SYNC_DIRECT: sync_event = trig_event; // R01
      hpmm_pkg::HPMM_SYNC_TMRB_ZM: sync_event = reminder_ff & TMRB_ZERO_MATCH; // R02
      hpmm_pkg::HPMM_SYNC_TMRA_ZM_UP: sync_event = reminder_ff & TMRA_ZERO_MATCH_UP; // R02
      hpmm_pkg::HPMM_SYNC_RSV: sync_event = 1'b0; // R02
    endcase
  end

  // Pattern transfer strobe: hardware sync event or software request
  assign strobe = sync_event | out_sw_req; // R12
  assign PATTERN_TRANSFER_STROBE = strobe;

  // Reminder: a new trigger in the transfer cycle stays pending, set beats clear
  // With sync code 11 no transfer ever comes, so the reminder waits for a software request
  always_comb begin
    nxt_reminder = reminder_ff & ~strobe; // R20
    if (trig_event && (sync_sel != hpmm_pkg::HPMM_SYNC_DIRECT) && !(reminder_ff && sync_event)) begin
      nxt_reminder = 1'b1; // R20
    end
    if (trig_event && reminder_ff && sync_event) begin
      nxt_reminder = 1'b1;
    end
  end

  // Reminder register
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      reminder_ff <= 1'b0;
    end else begin
      reminder_ff <= nxt_reminder;
    end
  end

  // Transfer-done flag: set by strobe, cleared by writing one; set wins
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      transfer_done_flag_ff <= 1'b0;
    end else if (strobe) begin
      transfer_done_flag_ff <= 1'b1; // R14
    end else if (wr_status && PWDATA[`HPMM_STS_DONE]) begin
      transfer_done_flag_ff <= 1'b0;
    end
  end

  // Shadow pattern register, software writable
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      current_hall_shadow_ff <= 3'h0;
      expected_hall_shadow_ff <= 3'h0;
      output_pattern_shadow_ff <= 6'h00;
    end else if (wr_shadow) begin
      current_hall_shadow_ff <= PWDATA[`HPMM_PAT_CUR_HI:`HPMM_PAT_CUR_LO]; // R07
      expected_hall_shadow_ff <= PWDATA[`HPMM_PAT_EXP_HI:`HPMM_PAT_EXP_LO]; // R07
      output_pattern_shadow_ff <= PWDATA[`HPMM_PAT_OUT_HI:`HPMM_PAT_OUT_LO]; // R07
    end
  end

  // Active Hall patterns; a software request copies the value being written
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      current_hall_pattern_ff <= 3'h0;
      expected_hall_pattern_ff <= 3'h0;
    end else if (hall_sw_req) begin
      current_hall_pattern_ff <= PWDATA[`HPMM_PAT_CUR_HI:`HPMM_PAT_CUR_LO]; // R13
      expected_hall_pattern_ff <= PWDATA[`HPMM_PAT_EXP_HI:`HPMM_PAT_EXP_LO]; // R13
    end else if (CORRECT_HALL_EVENT) begin
      current_hall_pattern_ff <= current_hall_shadow_ff; // R11
      expected_hall_pattern_ff <= expected_hall_shadow_ff; // R11
    end
  end

  // Active output pattern moves only on the transfer strobe
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      output_pattern_ff <= 6'h00;
    end else if (out_sw_req) begin
      output_pattern_ff <= PWDATA[`HPMM_PAT_OUT_HI:`HPMM_PAT_OUT_LO]; // R12
    end else if (sync_event) begin
      output_pattern_ff <= output_pattern_shadow_ff; // R12 R14
    end
  end

  // Modulation control register
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      output_modulation_control_ff <= `HPMM_MOD_RST;
    end else if (wr_mod) begin
      output_modulation_control_ff <= PWDATA[15:0] & `HPMM_MOD_MASK; // R04
    end
  end

  // Transfer control; unused bits 7 and 3 are kept at zero
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      xfer_ctl_ff <= `HPMM_XFR_RST;
    end else if (wr_xfer) begin
      xfer_ctl_ff <= {PWDATA[15:8], 1'b0, PWDATA[6:4], 1'b0, PWDATA[2:0]};
    end
  end

  // Output stage; registered so the inverter never sees decode glitches
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      OUTPUT_MOD <= 6'h00;
      TIMER_B_COMPARE_OUTPUT <= 1'b0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        OUTPUT_MOD[i] <= mod_out(output_modulation_control_ff[`HPMM_MOD_TMRA_EN_LO + i], TMRA_PWM[i], // R04 R05
                                 output_modulation_control_ff[`HPMM_MOD_TMRB_EN_LO + i], TMRB_PWM[i],
                                 output_modulation_control_ff[`HPMM_MOD_MCM_EN], output_pattern_ff[i]); // R06 R19
      end
      TIMER_B_COMPARE_OUTPUT <= output_modulation_control_ff[`HPMM_MOD_TMRB_OE] & TMRB_COMPARE_RAW; // R03
    end
  end

  // Read mux; request bits read as zero
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    unique case (PADDR)
      `HPMM_ADDR_MODCTL: nxt_prdata[15:0] = output_modulation_control_ff;
      `HPMM_ADDR_SHADOW: nxt_prdata[13:0] = {current_hall_shadow_ff, expected_hall_shadow_ff,
                                             2'h0, output_pattern_shadow_ff};
      `HPMM_ADDR_ACTIVE: nxt_prdata[13:0] = {current_hall_pattern_ff, expected_hall_pattern_ff,
                                             2'h0, output_pattern_ff};
      `HPMM_ADDR_XFRCTL: nxt_prdata[15:0] = xfer_ctl_ff;
      `HPMM_ADDR_STATUS: nxt_prdata[4:0] = {hall_sample, reminder_ff, transfer_done_flag_ff};
      default: nxt_prdata = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup cycle, stable through the access cycle
  // Reads never touch a flag; the done flag clears only by writing one
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd_setup) begin
      PRDATA <= nxt_prdata;
    end
  end
endmodule // hpmm_top
`default_nettype wire

// File: verification/hpmm_hall_model.sv
// Behavioural model of the three Hall sensors facing the block
`default_nettype none
module hpmm_hall_model (
  // Clock
  input wire logic clk,
  // Commanded rotor position and spike
  input wire logic [2:0] target,
  input wire logic bounce,
  // Sensor levels
  output logic [2:0] hall
);
  timeunit 1ns;
  timeprecision 100ps;
  // Sensors start at rest so the block sees a defined level from time zero
  initial hall = 3'h0;
  // Levels follow the rotor; a commanded spike inverts all three while it lasts
  always @(posedge clk) begin
    hall <= bounce ? ~target : target;
  end
endmodule // hpmm_hall_model
`default_nettype wire

// File: verification/hpmm_top_checker.sv
// Port-level assertions for the Hall pattern modulation block
`include "hpmm_defs.svh"
`default_nettype none
module hpmm_top_checker (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // Bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PSLVERR,
  // Sensors and timers
  input wire logic [2:0] HALL_INPUT,
  input wire logic TMRB_ZERO_MATCH,
  input wire logic TMRB_PERIOD_MATCH,
  input wire logic TMRA_ZERO_MATCH_UP,
  input wire logic [5:0] TMRA_PWM,
  input wire logic [5:0] TMRB_PWM,
  input wire logic TMRB_COMPARE_RAW,
  // Outputs
  input wire logic [5:0] OUTPUT_MOD,
  input wire logic TIMER_B_COMPARE_OUTPUT,
  input wire logic CORRECT_HALL_EVENT,
  input wire logic WRONG_HALL_EVENT,
  input wire logic PATTERN_TRANSFER_STROBE
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mod_ff;
  logic [15:0] xfr_ff;
  logic [8:0] quiet_ff;
  logic wr;
  logic sw_out;
  logic mapped;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // Decoded bus writes
  assign wr = PSEL && PENABLE && PWRITE;
  assign sw_out = wr && PADDR == `HPMM_ADDR_SHADOW && PWDATA[14];
  assign mapped = PADDR inside {`HPMM_ADDR_MODCTL, `HPMM_ADDR_SHADOW, `HPMM_ADDR_ACTIVE, `HPMM_ADDR_XFRCTL,
    `HPMM_ADDR_STATUS};
  // Mirror of the modulation control register, updated at the same edge as the block's own copy
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) mod_ff <= 16'h0000;
    else if (wr && PADDR == `HPMM_ADDR_MODCTL) mod_ff <= PWDATA[15:0];
  end
  // Mirror of the transfer control register
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) xfr_ff <= 16'h0000;
    else if (wr && PADDR == `HPMM_ADDR_XFRCTL) xfr_ff <= PWDATA[15:0];
  end
  // Cycles since the last sensor change, saturating so it never wraps back into the window
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || HALL_INPUT != $past(HALL_INPUT)) quiet_ff <= 9'h000;
    else if (quiet_ff != 9'h1FF) quiet_ff <= quiet_ff + 9'h001;
  end
  chk_tmrb_gate: assert property (1'h1 |=> TIMER_B_COMPARE_OUTPUT ==
    ($past(mod_ff[15]) & $past(TMRB_COMPARE_RAW))) else $error("timer_b compare output gate wrong");
  chk_timer_modulation: assert property (!mod_ff[7] |=> OUTPUT_MOD ==
    (($past(mod_ff[5:0]) & $past(TMRA_PWM)) | ($past(mod_ff[13:8]) & $past(TMRB_PWM))))
    else $error("timer modulation of outputs wrong");
  chk_event_exclusive: assert property (!(CORRECT_HALL_EVENT && WRONG_HALL_EVENT))
    else $error("correct and wrong Hall events together");
  chk_event_cause: assert property ((CORRECT_HALL_EVENT || WRONG_HALL_EVENT) |-> quiet_ff < 9'h12C)
    else $error("Hall event without a recent sensor change");
  chk_strobe_cause: assert property (PATTERN_TRANSFER_STROBE && !sw_out && !$past(sw_out) |->
    xfr_ff[5:4] == 2'h0 || (xfr_ff[5:4] == 2'h1 && TMRB_ZERO_MATCH) || (xfr_ff[5:4] == 2'h2 && TMRA_ZERO_MATCH_UP))
    else $error("pattern strobe without its sync event");
  chk_trig_idle: assert property (xfr_ff[5:4] == 2'h0 && (xfr_ff[2:0] == 3'h0 || xfr_ff[2:1] == 2'h3)
    && !sw_out && !$past(sw_out) |-> !PATTERN_TRANSFER_STROBE) else $error("strobe with no trigger selected");
  chk_direct_period: assert property (xfr_ff[5:0] == 6'h02 && TMRB_PERIOD_MATCH |-> PATTERN_TRANSFER_STROBE)
    else $error("direct mode strobe missing");
  chk_bus_error: assert property (PSEL && PENABLE |-> PSLVERR == !mapped)
    else $error("bus error response wrong");
  cover property (CORRECT_HALL_EVENT);
  cover property (WRONG_HALL_EVENT);
  cover property (PATTERN_TRANSFER_STROBE && xfr_ff[5:4] == 2'h1);
endmodule // hpmm_top_checker
bind hpmm_top hpmm_top_checker chk_i (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSLVERR(PSLVERR), .HALL_INPUT(HALL_INPUT),
  .TMRB_ZERO_MATCH(TMRB_ZERO_MATCH), .TMRB_PERIOD_MATCH(TMRB_PERIOD_MATCH), .TMRA_ZERO_MATCH_UP(TMRA_ZERO_MATCH_UP),
  .TMRA_PWM(TMRA_PWM), .TMRB_PWM(TMRB_PWM), .TMRB_COMPARE_RAW(TMRB_COMPARE_RAW), .OUTPUT_MOD(OUTPUT_MOD),
  .TIMER_B_COMPARE_OUTPUT(TIMER_B_COMPARE_OUTPUT), .CORRECT_HALL_EVENT(CORRECT_HALL_EVENT),
  .WRONG_HALL_EVENT(WRONG_HALL_EVENT), .PATTERN_TRANSFER_STROBE(PATTERN_TRANSFER_STROBE));
`default_nettype wire

// File: verification/hpmm_top_bench.sv
// Self-checking bench for the Hall pattern modulation block
`include "hpmm_defs.svh"
`default_nettype none
module hpmm_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [15:0] wr; logic [15:0] rd; logic [5:0] a; logic [5:0] b; logic [5:0] o;} hpmm_row_t;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, raw = 1'h0, bounce = 1'h0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [2:0] target = 3'h0;
  logic [5:0] tev = 6'h00, apwm = 6'h00, bpwm = 6'h00;
  logic [31:0] prdata, q;
  logic [5:0] out_mod;
  logic [2:0] hall;
  logic pready, pslverr, tb_out, che, whe, stb, e;
  int err_count = 0, checks_done = 0, n;
  logic [15:0] adr [5] = '{`HPMM_ADDR_MODCTL, `HPMM_ADDR_SHADOW, `HPMM_ADDR_ACTIVE, `HPMM_ADDR_XFRCTL,
    `HPMM_ADDR_STATUS};
  // Timer enables in both fields, channel order, and the mask of unused bits
  hpmm_row_t rows [4] = '{'{16'h0015, 16'h0015, 6'h3F, 6'h3F, 6'h15}, '{16'h2A00, 16'h2A00, 6'h3F, 6'h3C, 6'h28},
    '{16'h8100, 16'h8100, 6'h00, 6'h01, 6'h01}, '{16'hFFFF, 16'hBFBF, 6'h3F, 6'h3F, 6'h00}};
  hpmm_hall_model model (.clk(clk), .target(target), .bounce(bounce), .hall(hall));
  hpmm_top uut (.CLK_SYS(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .HALL_INPUT(hall),
    .TMRB_ZERO_MATCH(tev[0]), .TMRB_PERIOD_MATCH(tev[1]), .TMRA_ZERO_MATCH_UP(tev[2]), .TMRA_ONE_MATCH_DOWN(tev[3]),
    .TMRA_CH1_COMPARE_UP(tev[4]), .TMRA_PERIOD_MATCH_UP(tev[5]), .TMRA_PWM(apwm), .TMRB_PWM(bpwm),
    .TMRB_COMPARE_RAW(raw), .OUTPUT_MOD(out_mod), .TIMER_B_COMPARE_OUTPUT(tb_out), .CORRECT_HALL_EVENT(che),
    .WRONG_HALL_EVENT(whe), .PATTERN_TRANSFER_STROBE(stb));
  // 100 MHz system clock
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish();
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  // One bus transfer; request held until ready is seen high, then released a cycle apart from the next
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
    if (k >= 20) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  // Counts cycles until a Hall event; short windows are quiet-period checks, long ones are timeouts
  task automatic wait_evt(input int lim);
    n = 0;
    while (che !== 1'h1 && whe !== 1'h1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim && lim > 50) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  // One-cycle timer event, strobe looked at once the launching edge has settled
  task automatic pulse(input logic [5:0] v, input logic x);
    tev <= v;
    #1 chk("strobe", 16'(x), 16'(stb));
    @(posedge clk);
    tev <= 6'h00;
    @(posedge clk);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    foreach (adr[i]) begin
      apb(1'h0, adr[i], 32'h0);
      chk("reset value", 16'h0000, q[15:0]);
    end
    apb(1'h0, 16'hE8D4, 32'h0);
    chk("unmapped error", 16'h0001, 16'(e));
    foreach (rows[i]) begin
      apb(1'h1, `HPMM_ADDR_MODCTL, 32'(rows[i].wr));
      apb(1'h0, `HPMM_ADDR_MODCTL, 32'h0);
      chk("modctl", rows[i].rd, q[15:0]);
      apwm <= rows[i].a;
      bpwm <= rows[i].b;
      raw <= 1'h1;
      repeat (2) @(posedge clk);
      chk("outputs", 16'(rows[i].o), 16'(out_mod));
      chk("timer_b output", 16'(rows[i].rd[15]), 16'(tb_out));
    end
    // Awkward cases: Hall table walk, spike, wrong pattern, trigger and sync codes
    apb(1'h1, `HPMM_ADDR_XFRCTL, 32'h0001);
    apb(1'h1, `HPMM_ADDR_SHADOW, 32'h8B2A);
    apb(1'h0, `HPMM_ADDR_ACTIVE, 32'h0);
    chk("hall request copy", 16'h0B00, q[15:0]);
    apb(1'h1, `HPMM_ADDR_SHADOW, 32'h1A15);
    apb(1'h1, `HPMM_ADDR_MODCTL, 32'h0080);
    target <= 3'h1;
    wait_evt(40);
    chk("current pattern quiet", 16'h0028, 16'(n));
    target <= 3'h3;
    wait_evt(100);
    chk("correct event", 16'h0001, 16'(che));
    chk("unfiltered delay", 16'h0001, 16'(n < 9));
    apb(1'h0, `HPMM_ADDR_ACTIVE, 32'h0);
    chk("active after event", 16'h1A15, q[15:0]);
    chk("pattern outputs", 16'h0015, 16'(out_mod));
    apb(1'h0, `HPMM_ADDR_STATUS, 32'h0);
    chk("done flag", 16'h0001, 16'(q[0]));
    apb(1'h1, `HPMM_ADDR_STATUS, 32'h1);
    // Software has put all three timer_a channels in Hall mode before enabling the filter
    apb(1'h1, `HPMM_ADDR_XFRCTL, 32'h0841);
    bounce <= 1'h1;
    @(posedge clk);
    bounce <= 1'h0;
    wait_evt(40);
    chk("spike filtered", 16'h0028, 16'(n));
    target <= 3'h6;
    wait_evt(100);
    chk("wrong event", 16'h0001, 16'(whe));
    chk("filter delay", 16'h0001, 16'(n > 8 && n < 20));
    for (int k = 0; k < 8; k++) begin
      apb(1'h1, `HPMM_ADDR_XFRCTL, 32'(k));
      pulse((k inside {[2:5]}) ? 6'(1 << ((k == 2) ? 1 : k)) : 6'h3A, k inside {[2:5]});
    end
    for (int s = 1; s < 4; s++) begin
      // Clear the sticky done flag so codes 01 and 10 must set it afresh and code 11 must leave it clear
      apb(1'h1, `HPMM_ADDR_STATUS, 32'h1);
      apb(1'h1, `HPMM_ADDR_XFRCTL, 32'((s << 4) | 2));
      pulse(6'h02, 1'h0);
      pulse(6'h01, s == 1);
      pulse(6'h04, s == 2);
      apb(1'h0, `HPMM_ADDR_STATUS, 32'h0);
      chk("reminder", 16'(s == 3), 16'(q[1]));
      chk("done", 16'(s != 3), 16'(q[0]));
      chk("sampled pattern", 16'h0006, 16'(q[4:2]));
    end
    // Software output request moves the written pattern at once
    apb(1'h1, `HPMM_ADDR_SHADOW, 32'h5A2A);
    apb(1'h0, `HPMM_ADDR_ACTIVE, 32'h0);
    chk("output request copy", 16'h1A2A, q[15:0]);
    chk("request pattern outputs", 16'h002A, 16'(out_mod));
    tally_and_finish();
  end
endmodule // hpmm_top_bench
`default_nettype wire
